// file: design/dlpb_defs.svh
/*
  Constants of the log sector builder: sector offsets, field values and timing figures.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef DLPB_DEFS_SVH
`define DLPB_DEFS_SVH

`define DLPB_LAST_IDX      9'h1FF
`define DLPB_LOG_DIR       8'h00
`define DLPB_LOG_XERR      8'h03
`define DLPB_LOG_STATS     8'h04
`define DLPB_LOG_XTEST     8'h07
`define DLPB_LOG_PWRC      8'h08
`define DLPB_LOG_IDENT     8'h30
`define DLPB_DIR_VER_LO    8'h01
`define DLPB_DIR_VER_HI    8'h00
`define DLPB_VND_FIRST     8'h80
`define DLPB_VND_LAST      8'h9F
`define DLPB_VND_SECTORS   16'h0010
`define DLPB_SATA_FIRST    8'h10
`define DLPB_SATA_LAST     8'h17
`define DLPB_SATA_NCQ      8'h10
`define DLPB_SATA_PHY      8'h11
`define DLPB_SATA_NDATA    8'h12
`define DLPB_SATA_REBUILD  8'h15
`define DLPB_XERR_VERSION  8'h01
`define DLPB_XERR_IDX_LO   9'h002
`define DLPB_XERR_IDX_HI   9'h003
`define DLPB_XERR_ENT0     9'h004
`define DLPB_XERR_ENT_END  9'h1F3
`define DLPB_XERR_CNT_LO   9'h1F4
`define DLPB_XERR_CNT_HI   9'h1F5
`define DLPB_ERR_IDX_MAX   3'h4
`define DLPB_REC_ERR       3'h5
`define DLPB_CREC_LAST     6'h11
`define DLPB_EREC_LAST     6'h21
`define DLPB_CREC_CTRL     6'h00
`define DLPB_CREC_HEAD     6'h0B
`define DLPB_CREC_OPC      6'h0C
`define DLPB_CREC_TS       6'h0E
`define DLPB_EREC_ERR      6'h01
`define DLPB_EREC_PAIR     6'h02
`define DLPB_EREC_HEAD     6'h0A
`define DLPB_EREC_STAT     6'h0B
`define DLPB_EREC_STATE    6'h1F
`define DLPB_EREC_HRS      6'h20
`define DLPB_STAT_REV_P0   16'h0001
`define DLPB_STAT_REV_P1   16'h0002
`define DLPB_STAT_PGNUM    9'h002
`define DLPB_STAT_NLIST    9'h008
`define DLPB_STAT_LIST0    9'h009
`define DLPB_STAT_LIST1    9'h00A
`define DLPB_STAT_NPAGES   8'h02
`define DLPB_CNT_MAX       16'hFFFF
`define DLPB_MS_NS         1000000
`define DLPB_CLK_NS        8

`endif

// file: design/dlpb_pkg.sv
/*
  Types of the log sector builder: stream state, device state codes, stored records.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dlpb_pkg;
  typedef enum logic {DLPB_IDLE, DLPB_STREAM} dlpb_state_t;
  typedef enum logic [3:0] {
    DLPB_ST_UNKNOWN = 4'h0, DLPB_ST_SLEEP = 4'h1, DLPB_ST_STANDBY = 4'h2,
    DLPB_ST_ACTIVE = 4'h3, DLPB_ST_OFFLINE = 4'h4
  } dlpb_devstate_t;
  typedef struct packed {
    logic [7:0]       ctrl;
    logic [4:0][15:0] pair;
    logic [7:0]       head;
    logic [7:0]       opc;
    logic [31:0]      ts;
  } dlpb_crec_t;
  typedef struct packed {
    dlpb_crec_t [4:0] cmd;
    logic [7:0]       err;
    logic [3:0][15:0] pair;
    logic [7:0]       head;
    logic [7:0]       status;
    logic [7:0]       state;
    logic [15:0]      hours;
  } dlpb_entry_t;
endpackage

// file: design/dlpb_top.sv
/*
  Log sector builder: directory, extended error log and statistics sectors, streamed a byte a cycle.
  Assumes a command layer that reports shadow writes, commands and errors, and requests whole sectors.
*/
`timescale 1ns/1ps
`include "dlpb_defs.svh"
`default_nettype none

module dlpb_top
  import dlpb_pkg::*;
#(
  parameter int          MS_CYCLES  = `DLPB_MS_NS / `DLPB_CLK_NS,
  parameter logic [3:0]  STATE_VEND = 4'h0,
  parameter logic [15:0] CNT_XERR   = 16'h0001,
  parameter logic [15:0] CNT_STATS  = 16'h0002,
  parameter logic [15:0] CNT_XTEST  = 16'h0001,
  parameter logic [15:0] CNT_PWRC   = 16'h0001,
  parameter logic [15:0] CNT_IDENT  = 16'h0001
) (
  input  wire logic           clock,
  input  wire logic           rst_n,
  input  wire logic           clk_en,
  input  wire logic           ncq_en,
  input  wire logic           phy_cnt_sup,
  input  wire logic           ncq_nodata_sup,
  input  wire logic           rebuild_sup,
  input  wire logic           sh_wr,
  input  wire logic [2:0]     sh_sel,
  input  wire logic [7:0]     sh_data,
  input  wire logic           cmd_push,
  input  wire logic [7:0]     cmd_ctrl,
  input  wire logic [7:0]     cmd_head,
  input  wire logic [7:0]     cmd_opcode,
  input  wire logic           err_push,
  input  wire logic           err_malformed,
  input  wire logic           err_device,
  input  wire logic [7:0]     err_error,
  input  wire logic [15:0]    err_sc_rd,
  input  wire logic [15:0]    err_sn_rd,
  input  wire logic [15:0]    err_cl_rd,
  input  wire logic [15:0]    err_ch_rd,
  input  wire logic [7:0]     err_head,
  input  wire logic [7:0]     err_status,
  input  wire dlpb_devstate_t err_state,
  input  wire logic [15:0]    err_hours,
  input  wire logic           rd_req,
  input  wire logic [7:0]     rd_log,
  input  wire logic [7:0]     rd_page,
  output logic                rd_busy,
  output logic                rd_valid,
  output logic [7:0]          rd_data,
  output logic [8:0]          rd_offset,
  output logic                rd_last,
  output logic [2:0]          err_index,
  output logic [15:0]         err_count
);

  localparam int MSW = $clog2(MS_CYCLES + 1);

  dlpb_state_t      st_ff, nxt_st;
  logic [7:0]       log_ff, nxt_log, page_ff, nxt_page;
  logic [8:0]       idx_ff, nxt_idx;
  logic [1:0]       ent_ff, nxt_ent;
  logic [2:0]       rec_ff, nxt_rec;
  logic [5:0]       roff_ff, nxt_roff;
  logic [7:0]       csum_ff, nxt_csum;
  logic             busy_ff, nxt_busy, valid_ff, nxt_valid, last_ff, nxt_last;
  logic [7:0]       data_ff, nxt_data;
  logic [8:0]       off_ff, nxt_off;
  logic [MSW-1:0]   tick_ff, nxt_tick;
  logic [31:0]      ms_ff, nxt_ms;
  logic [4:0][15:0] sh_ff, nxt_sh;
  dlpb_crec_t [4:0] hist_ff, nxt_hist;
  dlpb_entry_t [3:0] ent_mem_ff, nxt_ent_mem;
  logic [3:0]       ev_ff, nxt_ev;
  logic [2:0]       index_ff, nxt_index;
  logic [15:0]      cnt_ff, nxt_cnt;
  logic [7:0]       cur_byte;

  // directory count for log N; sata flag bytes sit inside the count area
  function automatic logic [15:0] dir_count(input logic [7:0] n);
    logic [15:0] c;
    c = 16'h0000;
    if (n >= `DLPB_VND_FIRST && n <= `DLPB_VND_LAST) c = `DLPB_VND_SECTORS;
    else if (n == `DLPB_LOG_XERR) c = CNT_XERR;
    else if (n == `DLPB_LOG_STATS) c = CNT_STATS;
    else if (n == `DLPB_LOG_XTEST) c = CNT_XTEST;
    else if (n == `DLPB_LOG_PWRC) c = CNT_PWRC;
    else if (n == `DLPB_LOG_IDENT) c = CNT_IDENT;
    else if (n >= `DLPB_SATA_FIRST && n <= `DLPB_SATA_LAST) begin
      c = 16'h0000;
      if (n == `DLPB_SATA_NCQ) c = {15'h0000, ncq_en};
      if (n == `DLPB_SATA_PHY) c = {15'h0000, phy_cnt_sup};
      if (n == `DLPB_SATA_NDATA) c = {15'h0000, ncq_nodata_sup};
      if (n == `DLPB_SATA_REBUILD) c = {15'h0000, rebuild_sup};
    end
    return c;
  endfunction

  function automatic logic [15:0] stat_rev(input logic [7:0] p);
    logic [15:0] r;
    r = 16'h0000;
    if (p == 8'h00) r = `DLPB_STAT_REV_P0;
    if (p == 8'h01) r = `DLPB_STAT_REV_P1;
    return r;
  endfunction

  // byte at the current stream position
  always_comb begin
    dlpb_entry_t e;
    dlpb_crec_t  c;
    logic [15:0] w;
    logic [15:0] rv;
    logic [2:0]  k;
    e = ent_mem_ff[ent_ff];
    c = e.cmd[rec_ff];
    w = 16'h0000;
    rv = stat_rev(page_ff);
    k = 3'h0;
    cur_byte = 8'h00;
    if (log_ff == `DLPB_LOG_DIR) begin
      if (idx_ff[8:1] == 8'h00) cur_byte = idx_ff[0] ? `DLPB_DIR_VER_HI : `DLPB_DIR_VER_LO;
      else begin
        w = dir_count(idx_ff[8:1]);
        cur_byte = idx_ff[0] ? w[15:8] : w[7:0];
      end
    end else if (log_ff == `DLPB_LOG_XERR) begin
      if (idx_ff == 9'h000) cur_byte = `DLPB_XERR_VERSION;
      else if (idx_ff == `DLPB_XERR_IDX_LO) cur_byte = {5'h00, index_ff};
      else if (idx_ff == `DLPB_XERR_CNT_LO) cur_byte = cnt_ff[7:0];
      else if (idx_ff == `DLPB_XERR_CNT_HI) cur_byte = cnt_ff[15:8];
      else if (idx_ff == `DLPB_LAST_IDX) cur_byte = 8'h00 - csum_ff;
      else if (idx_ff >= `DLPB_XERR_ENT0 && idx_ff <= `DLPB_XERR_ENT_END && ev_ff[ent_ff]) begin
        if (rec_ff != `DLPB_REC_ERR) begin
          k = 3'((roff_ff - 6'h01) >> 1);
          if (roff_ff == `DLPB_CREC_CTRL) cur_byte = c.ctrl;
          else if (roff_ff < `DLPB_CREC_HEAD) cur_byte = roff_ff[0] ? c.pair[k][7:0] : c.pair[k][15:8];
          else if (roff_ff == `DLPB_CREC_HEAD) cur_byte = c.head;
          else if (roff_ff == `DLPB_CREC_OPC) cur_byte = c.opc;
          else if (roff_ff >= `DLPB_CREC_TS) cur_byte = c.ts[8*(roff_ff-`DLPB_CREC_TS) +: 8];
        end else begin
          k = 3'((roff_ff - `DLPB_EREC_PAIR) >> 1);
          if (roff_ff == `DLPB_EREC_ERR) cur_byte = e.err;
          else if (roff_ff >= `DLPB_EREC_PAIR && roff_ff < `DLPB_EREC_HEAD)
            cur_byte = roff_ff[0] ? e.pair[k[1:0]][15:8] : e.pair[k[1:0]][7:0];
          else if (roff_ff == `DLPB_EREC_HEAD) cur_byte = e.head;
          else if (roff_ff == `DLPB_EREC_STAT) cur_byte = e.status;
          else if (roff_ff == `DLPB_EREC_STATE) cur_byte = e.state;
          else if (roff_ff == `DLPB_EREC_HRS) cur_byte = e.hours[7:0];
          else if (roff_ff == `DLPB_EREC_STATE + 6'h02) cur_byte = e.hours[15:8];
        end
      end
    end else if (log_ff == `DLPB_LOG_STATS && rv != 16'h0000) begin
      if (idx_ff == 9'h000) cur_byte = rv[7:0];
      else if (idx_ff == 9'h001) cur_byte = rv[15:8];
      else if (idx_ff == `DLPB_STAT_PGNUM) cur_byte = page_ff;
      else if (page_ff == 8'h00 && idx_ff == `DLPB_STAT_NLIST) cur_byte = `DLPB_STAT_NPAGES;
      else if (page_ff == 8'h00 && idx_ff == `DLPB_STAT_LIST1) cur_byte = 8'h01;
    end
  end

  // sector stream: one byte a cycle, checksum of all earlier bytes kept alongside
  always_comb begin
    nxt_st = st_ff;
    nxt_log = log_ff;
    nxt_page = page_ff;
    nxt_idx = idx_ff;
    nxt_ent = ent_ff;
    nxt_rec = rec_ff;
    nxt_roff = roff_ff;
    nxt_csum = csum_ff;
    nxt_valid = 1'b0;
    nxt_last = 1'b0;
    nxt_data = data_ff;
    nxt_off = off_ff;
    unique case (st_ff)
      DLPB_IDLE: begin
        if (rd_req) begin
          nxt_st = DLPB_STREAM;
          nxt_log = rd_log;
          nxt_page = rd_page;
          nxt_idx = 9'h000;
          nxt_ent = 2'h0;
          nxt_rec = 3'h0;
          nxt_roff = 6'h00;
          nxt_csum = 8'h00;
        end
      end
      DLPB_STREAM: begin
        nxt_valid = 1'b1;
        nxt_data = cur_byte;
        nxt_off = idx_ff;
        nxt_csum = csum_ff + cur_byte;
        nxt_idx = idx_ff + 9'h001;
        if (idx_ff >= `DLPB_XERR_ENT0 && idx_ff <= `DLPB_XERR_ENT_END) begin
          nxt_roff = roff_ff + 6'h01;
          if (roff_ff == ((rec_ff == `DLPB_REC_ERR) ? `DLPB_EREC_LAST : `DLPB_CREC_LAST)) begin
            nxt_roff = 6'h00;
            nxt_rec = (rec_ff == `DLPB_REC_ERR) ? 3'h0 : rec_ff + 3'h1;
            if (rec_ff == `DLPB_REC_ERR) nxt_ent = ent_ff + 2'h1;
          end
        end
        if (idx_ff == `DLPB_LAST_IDX) begin
          nxt_last = 1'b1;
          nxt_st = DLPB_IDLE;
        end
      end
    endcase
    nxt_busy = (nxt_st == DLPB_STREAM);
  end

  // power-on millisecond clock for command timestamps
  always_comb begin
    nxt_tick = tick_ff + MSW'(1);
    nxt_ms = ms_ff;
    if (tick_ff == MSW'(MS_CYCLES - 1)) begin
      nxt_tick = '0;
      nxt_ms = ms_ff + 32'h0000_0001;
    end
  end

  // shadow pairs, command history and error capture
  always_comb begin
    dlpb_crec_t  nc;
    dlpb_entry_t ne;
    logic [1:0]  slot;
    nc = '0;
    ne = '0;
    nxt_sh = sh_ff;
    nxt_hist = hist_ff;
    nxt_ent_mem = ent_mem_ff;
    nxt_ev = ev_ff;
    nxt_index = index_ff;
    nxt_cnt = cnt_ff;
    slot = index_ff[1:0];
    if (sh_wr && sh_sel <= 3'h4) nxt_sh[sh_sel] = {sh_ff[sh_sel][7:0], sh_data};
    nc.ctrl = cmd_ctrl;
    nc.pair = sh_ff;
    nc.head = cmd_head;
    nc.opc = cmd_opcode;
    nc.ts = ms_ff;
    if (cmd_push) nxt_hist = {nc, hist_ff[4:1]};
    ne.cmd = hist_ff;
    ne.err = err_error;
    ne.pair = {err_ch_rd, err_cl_rd, err_sn_rd, err_sc_rd};
    ne.head = err_head;
    ne.status = err_status;
    ne.state = {STATE_VEND, err_state};
    ne.hours = err_hours;
    // index 4 maps back to slot 0, so the fifth error lands on the first entry
    if (err_push && !err_malformed) begin
      nxt_ent_mem[slot] = ne;
      nxt_ev[slot] = 1'b1;
      nxt_index = {1'b0, slot} + 3'h1;
      if (err_device && cnt_ff != `DLPB_CNT_MAX) nxt_cnt = cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= DLPB_IDLE;
      log_ff <= 8'h00;
      page_ff <= 8'h00;
      idx_ff <= 9'h000;
      ent_ff <= 2'h0;
      rec_ff <= 3'h0;
      roff_ff <= 6'h00;
      csum_ff <= 8'h00;
      busy_ff <= 1'b0;
      valid_ff <= 1'b0;
      last_ff <= 1'b0;
      data_ff <= 8'h00;
      off_ff <= 9'h000;
      tick_ff <= '0;
      ms_ff <= 32'h0000_0000;
      sh_ff <= '0;
      hist_ff <= '0;
      ent_mem_ff <= '0;
      ev_ff <= 4'h0;
      index_ff <= 3'h0;
      cnt_ff <= 16'h0000;
    end else if (clk_en) begin
      st_ff <= nxt_st;
      log_ff <= nxt_log;
      page_ff <= nxt_page;
      idx_ff <= nxt_idx;
      ent_ff <= nxt_ent;
      rec_ff <= nxt_rec;
      roff_ff <= nxt_roff;
      csum_ff <= nxt_csum;
      busy_ff <= nxt_busy;
      valid_ff <= nxt_valid;
      last_ff <= nxt_last;
      data_ff <= nxt_data;
      off_ff <= nxt_off;
      tick_ff <= nxt_tick;
      ms_ff <= nxt_ms;
      sh_ff <= nxt_sh;
      hist_ff <= nxt_hist;
      ent_mem_ff <= nxt_ent_mem;
      ev_ff <= nxt_ev;
      index_ff <= nxt_index;
      cnt_ff <= nxt_cnt;
    end
  end

  assign rd_busy = busy_ff;
  assign rd_valid = valid_ff;
  assign rd_data = data_ff;
  assign rd_offset = off_ff;
  assign rd_last = last_ff;
  assign err_index = index_ff;
  assign err_count = cnt_ff;

  // checks: sum of emitted bytes kept aside from the design's own sum
  logic [7:0] chk_sum_ff;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) chk_sum_ff <= 8'h00;
    else if (clk_en && valid_ff) chk_sum_ff <= last_ff ? 8'h00 : chk_sum_ff + data_ff;
  end

  sequence s_start(logic [7:0] lg);
    st_ff == DLPB_IDLE && rd_req && clk_en && rd_log == lg;
  endsequence
  sequence s_first_byte;
    clk_en ##1 (rd_valid && rd_offset == 9'h000);
  endsequence

  property p_dir_ver;
    @(posedge clock) disable iff (!rst_n) s_start(`DLPB_LOG_DIR) ##1 s_first_byte |-> rd_data == `DLPB_DIR_VER_LO;
  endproperty
  a_dir_ver: assert property (p_dir_ver) else $error("directory version low byte wrong");

  property p_vnd_cnt;
    @(posedge clock) disable iff (!rst_n)
      rd_valid && log_ff == `DLPB_LOG_DIR && rd_offset >= 9'h100 && rd_offset <= 9'h13F
      |-> rd_data == (rd_offset[0] ? 8'h00 : 8'h10);
  endproperty
  a_vnd_cnt: assert property (p_vnd_cnt) else $error("host vendor log count not sixteen");

  property p_sata_zero;
    @(posedge clock) disable iff (!rst_n)
      rd_valid && log_ff == `DLPB_LOG_DIR && rd_offset >= 9'h021 && rd_offset <= 9'h02F && rd_offset[0]
      |-> rd_data == 8'h00;
  endproperty
  a_sata_zero: assert property (p_sata_zero) else $error("odd serial flag byte not zero");

  property p_phy_flag;
    @(posedge clock) disable iff (!rst_n)
      clk_en && st_ff == DLPB_STREAM && log_ff == `DLPB_LOG_DIR && idx_ff == 9'h022
      |=> rd_data == {7'h00, $past(phy_cnt_sup)};
  endproperty
  a_phy_flag: assert property (p_phy_flag) else $error("link counter flag byte wrong");

  property p_xerr_ver;
    @(posedge clock) disable iff (!rst_n) s_start(`DLPB_LOG_XERR) ##1 s_first_byte |-> rd_data == `DLPB_XERR_VERSION;
  endproperty
  a_xerr_ver: assert property (p_xerr_ver) else $error("error log version not 01h");

  property p_idx_range;
    @(posedge clock) disable iff (!rst_n) err_index <= `DLPB_ERR_IDX_MAX && (err_index == 3'h0) == (ev_ff == 4'h0);
  endproperty
  a_idx_range: assert property (p_idx_range) else $error("error index out of range");

  property p_wrap;
    @(posedge clock) disable iff (!rst_n)
      clk_en && err_push && !err_malformed && err_index == 3'h4 |=> err_index == 3'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("fifth error did not wrap to entry one");

  property p_malformed;
    @(posedge clock) disable iff (!rst_n) err_push && err_malformed |=> $stable(err_count) && $stable(err_index);
  endproperty
  a_malformed: assert property (p_malformed) else $error("malformed command was logged");

  property p_sat;
    @(posedge clock) disable iff (!rst_n) err_count == `DLPB_CNT_MAX |=> err_count == `DLPB_CNT_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("error count wrapped");

  // saturation is out of reach in a short run, so the counting step itself is watched too
  property p_cnt_inc;
    @(posedge clock) disable iff (!rst_n)
      clk_en && err_push && !err_malformed && err_device && err_count != `DLPB_CNT_MAX
      |=> err_count == $past(err_count) + 16'h0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("device error not counted");

  property p_unsup;
    @(posedge clock) disable iff (!rst_n)
      rd_valid && log_ff == `DLPB_LOG_STATS && page_ff > 8'h01 |-> rd_data == 8'h00;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported page not zero");

  property p_csum;
    @(posedge clock) disable iff (!rst_n)
      rd_valid && rd_last && log_ff == `DLPB_LOG_XERR |-> 8'(chk_sum_ff + rd_data) == 8'h00;
  endproperty
  a_csum: assert property (p_csum) else $error("error sector checksum wrong");

endmodule

`default_nettype wire

// file: sim/dlpb_host.sv
/*
  host model: issues sector reads to the log builder.
  assumes the read port takes a request on an enabled edge while idle.
*/
`timescale 1ns/1ps
`default_nettype none
module dlpb_host (
  input  wire logic       clock,
  input  wire logic       clk_en,
  input  wire logic       rd_busy,
  output var  logic       rd_req,
  output var  logic [7:0] rd_log,
  output var  logic [7:0] rd_page
);
  initial begin
    rd_req  = 1'b0;
    rd_log  = 8'h00;
    rd_page = 8'h00;
  end
  // request held until the take edge; a refused request just waits
  task automatic issue(input logic [7:0] lg, input logic [7:0] pg, input int gap);
    // an edge always passes, so a release and the next request never share a time step
    repeat (gap + 1) @(posedge clock);
    #1;
    rd_req  = 1'b1;
    rd_log  = lg;
    rd_page = pg;
    do @(posedge clock); while (!(clk_en && !rd_busy));
    #1;
    rd_req  = 1'b0;
    // released lines never keep the last value
    rd_log  = ~lg;
    rd_page = ~pg;
  endtask
endmodule
`default_nettype wire

// file: sim/dlpb_top_tb_top.sv
/*
  bench of the log builder: event driver, host model, byte scoreboard.
  assumes the hand-over contract; timestamps are not predicted, only summed.
*/
`timescale 1ns/1ps
`default_nettype none
module dlpb_top_tb_top;
  import dlpb_pkg::*;
  localparam logic [3:0]  VEND = 4'hA;
  localparam logic [15:0] C3 = 16'h0001, C4 = 16'h0002, C7 = 16'h0001, C8 = 16'h0101, C30 = 16'h0201;
  logic           clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, stall = 1'b0;
  logic [3:0]     flg = 4'h0;
  logic           sh_wr = 1'b0, cmd_push = 1'b0, err_push = 1'b0, err_malformed = 1'b0, err_device = 1'b0;
  logic [2:0]     sh_sel = 3'h0, xi = 3'h0, err_index;
  logic [7:0]     sh_data = 8'h00, cmd_ctrl = 8'h00, cmd_head = 8'h00, cmd_opcode = 8'h00;
  logic [7:0]     err_error = 8'h00, err_head = 8'h00, err_status = 8'h00;
  logic [15:0]    err_sc_rd = 16'h0, err_sn_rd = 16'h0, err_cl_rd = 16'h0, err_ch_rd = 16'h0;
  logic [15:0]    err_hours = 16'h0, xc = 16'h0, err_count;
  dlpb_devstate_t err_state = DLPB_ST_UNKNOWN;
  logic           rd_req, rd_busy, rd_valid, rd_last;
  logic [7:0]     rd_log, rd_page, rd_data, sum = 8'h00;
  logic [8:0]     rd_offset;
  logic [31:0]    rnd = 32'h462d;
  logic [9:0]     exp_q[$];
  logic [9:0]     e;
  logic [8:0]     hrec[5][18];
  logic [8:0]     ent[4][124];
  logic [15:0]    sh[5];
  int             fails = 0, num_checks = 0, nerr = 0, idx = 0;
  wire logic ncq_en, phy_cnt_sup, ncq_nodata_sup, rebuild_sup;
  assign {rebuild_sup, ncq_nodata_sup, phy_cnt_sup, ncq_en} = flg;
  dlpb_top #(.MS_CYCLES(4), .STATE_VEND(VEND), .CNT_XERR(C3), .CNT_STATS(C4), .CNT_XTEST(C7),
    .CNT_PWRC(C8), .CNT_IDENT(C30)) dlpb_top_inst (
    .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .ncq_en(ncq_en), .phy_cnt_sup(phy_cnt_sup),
    .ncq_nodata_sup(ncq_nodata_sup), .rebuild_sup(rebuild_sup), .sh_wr(sh_wr), .sh_sel(sh_sel),
    .sh_data(sh_data), .cmd_push(cmd_push), .cmd_ctrl(cmd_ctrl), .cmd_head(cmd_head),
    .cmd_opcode(cmd_opcode), .err_push(err_push), .err_malformed(err_malformed), .err_device(err_device),
    .err_error(err_error), .err_sc_rd(err_sc_rd), .err_sn_rd(err_sn_rd), .err_cl_rd(err_cl_rd),
    .err_ch_rd(err_ch_rd), .err_head(err_head), .err_status(err_status), .err_state(err_state),
    .err_hours(err_hours), .rd_req(rd_req), .rd_log(rd_log), .rd_page(rd_page), .rd_busy(rd_busy),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_offset(rd_offset), .rd_last(rd_last),
    .err_index(err_index), .err_count(err_count));
  dlpb_host dlpb_host_inst (.clock(clock), .clk_en(clk_en), .rd_busy(rd_busy), .rd_req(rd_req),
    .rd_log(rd_log), .rd_page(rd_page));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always #4 clock = ~clock;
  // random stalls only while reading, events need an enabled edge
  always @(posedge clock) begin
    rnd = lfsr(rnd);
    clk_en <= #1 !stall || rnd[0];
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic step;
    @(posedge clock);
    #1;
  endtask
  function automatic logic [15:0] dcnt(input logic [7:0] n);
    case (n)
      8'h00: return 16'h0001;
      8'h03: return C3;
      8'h04: return C4;
      8'h07: return C7;
      8'h08: return C8;
      8'h30: return C30;
      8'h10: return {15'h0, flg[0]};
      8'h11: return {15'h0, flg[1]};
      8'h12: return {15'h0, flg[2]};
      8'h15: return {15'h0, flg[3]};
      default: return (n >= 8'h80 && n <= 8'h9F) ? 16'h0010 : 16'h0000;
    endcase
  endfunction
  task automatic rd(input logic [7:0] lg, input logic [7:0] pg);
    logic [15:0] w;
    logic [7:0]  d;
    logic        c;
    for (int o = 0; o < 512; o++) begin
      c = 1'b1;
      case (lg)
        8'h00: w = dcnt(o[8:1]);
        8'h03: w = (o < 2) ? 16'h0001 : (o < 4) ? {13'h0, xi} : (o == 500 || o == 501) ? xc : 16'h0;
        8'h04: w = (pg == 8'h00) ? ((o < 2) ? 16'h0001 : (o == 8 || o == 9) ? 16'h0002
               : (o == 10 || o == 11) ? 16'h0001 : 16'h0)
               : (pg == 8'h01) ? ((o < 2) ? 16'h0002 : (o < 4) ? 16'h0001 : 16'h0) : 16'h0;
        default: w = 16'h0000;
      endcase
      d = o[0] ? w[15:8] : w[7:0];
      if (lg == 8'h03 && o >= 4 && o < 500) {c, d} = ent[(o - 4) / 124][(o - 4) % 124];
      if (lg == 8'h03 && o == 511) c = 1'b0;
      exp_q.push_back({lg == 8'h03, c, d});
    end
    dlpb_host_inst.issue(lg, pg, int'(rnd[1:0]));
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    while ((exp_q.size() != 0 || rd_busy !== 1'b0) && n < 3000) begin
      step;
      n++;
    end
    if (n == 3000) check(16'h0001, 16'h0000);
    stall = 1'b0;
    step;
    step;
    $display("test %s done", name);
  endtask
  // scoreboard: one note per byte presented on an enabled cycle
  always @(posedge clock) begin
    if (clk_en && rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 10'h0FF;
      check({7'h0, rd_offset}, {7'h0, idx[8:0]});
      check({15'h0, rd_busy}, {15'h0, !rd_last});
      if (e[8]) check({8'h0, rd_data}, {8'h0, e[7:0]});
      sum = sum + rd_data;
      if (rd_last === 1'b1) begin
        check({7'h0, rd_offset}, 16'h01FF);
        if (e[9]) check({8'h0, sum}, 16'h0000);
        idx = 0;
        sum = 8'h00;
      end else idx++;
    end
  end
  // shadow pair becomes {old low, new}; selects above four are dropped
  task automatic shw(input logic [2:0] s);
    sh_wr = 1'b1;
    sh_sel = s;
    sh_data = rnd[7:0];
    if (s < 3'h5) sh[s] = {sh[s][7:0], rnd[7:0]};
    step;
    sh_wr = 1'b0;
    step;
  endtask
  task automatic cmd;
    cmd_push = 1'b1;
    cmd_ctrl = rnd[7:0];
    cmd_head = rnd[15:8];
    cmd_opcode = rnd[23:16];
    for (int r = 0; r < 4; r++) hrec[r] = hrec[r + 1];
    hrec[4][0] = {1'b1, rnd[7:0]};
    for (int k = 0; k < 10; k++) hrec[4][k + 1] = {1'b1, k[0] ? sh[k / 2][15:8] : sh[k / 2][7:0]};
    hrec[4][11] = {1'b1, rnd[15:8]};
    hrec[4][12] = {1'b1, rnd[23:16]};
    hrec[4][13] = 9'h100;
    for (int k = 14; k < 18; k++) hrec[4][k] = 9'h000;
    step;
    cmd_push = 1'b0;
    step;
  endtask
  task automatic errp(input logic mal, input logic dev, input dlpb_devstate_t st);
    int s;
    logic [63:0] pk;
    s = nerr % 4;
    err_push = 1'b1;
    err_malformed = mal;
    err_device = dev;
    err_state = st;
    err_error = rnd[7:0];
    err_head = rnd[15:8];
    err_status = rnd[23:16];
    err_hours = rnd[31:16];
    err_sc_rd = rnd[15:0];
    err_sn_rd = rnd[23:8];
    err_cl_rd = rnd[31:16];
    err_ch_rd = ~rnd[15:0];
    pk = {err_ch_rd, err_cl_rd, err_sn_rd, err_sc_rd};
    // a malformed command leaves log, index and count alone
    if (!mal) begin
      for (int k = 0; k < 90; k++) ent[s][k] = hrec[k / 18][k % 18];
      for (int k = 90; k < 124; k++) ent[s][k] = 9'h100;
      ent[s][91] = {1'b1, err_error};
      for (int k = 0; k < 8; k++) ent[s][92 + k] = {1'b1, pk[8 * k +: 8]};
      ent[s][100] = {1'b1, err_head};
      ent[s][101] = {1'b1, err_status};
      ent[s][121] = {1'b1, VEND, st};
      ent[s][122] = {1'b1, err_hours[7:0]};
      ent[s][123] = {1'b1, err_hours[15:8]};
      xi = 3'(s + 1);
      nerr++;
      if (dev && xc != 16'hFFFF) xc++;
    end
    step;
    err_push = 1'b0;
    step;
    check({13'h0, err_index}, {13'h0, xi});
    check(err_count, xc);
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    close_out;
  end
  initial begin
    foreach (hrec[r, k]) hrec[r][k] = 9'h100;
    foreach (ent[s, k]) ent[s][k] = 9'h100;
    foreach (sh[i]) sh[i] = 16'h0000;
    repeat (16) @(posedge clock);
    #1;
    rst_n = 1'b1;
    step;
    flg = rnd[3:0];
    stall = 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h00, 8'h00);
    drain("directory back to back");
    flg = ~flg;
    stall = 1'b1;
    rd(8'h00, 8'h00);
    drain("directory flags inverted");
    rd(8'h03, 8'h00);
    drain("empty error log");
    for (int i = 0; i < 8; i++) shw(i[2:0]);
    for (int i = 0; i < 5; i++) begin
      shw(rnd[2:0]);
      cmd;
    end
    for (int k = 0; k < 7; k++) begin
      errp(k == 2, k != 4, dlpb_devstate_t'(k % 5));
      shw(rnd[2:0]);
      cmd;
    end
    stall = 1'b1;
    rd(8'h03, 8'h00);
    drain("wrapped error log");
    stall = 1'b1;
    rd(8'h04, 8'h00);
    rd(8'h04, 8'h01);
    rd(8'h04, rnd[7:0] | 8'h02);
    rd(8'h07, 8'h00);
    drain("statistics pages");
    close_out;
  end
endmodule
`default_nettype wire
